// [ssdd_defs.svh]
`ifndef SSDD_DEFS_SVH
`define SSDD_DEFS_SVH

// ****************************************************************
// register indices (byte address = 4 * index)
// ****************************************************************
`define SSDD_IDX_DECODE_SEL   6'h01
`define SSDD_IDX_CONTROL      6'h04
`define SSDD_IDX_STATUS       6'h05
`define SSDD_IDX_DIGIT_BASE   6'h20
`define SSDD_IDX_DIGIT_LAST   6'h27

// ****************************************************************
// reset values and control fields
// ****************************************************************
`define SSDD_RST_DECODE_SEL   8'h00
`define SSDD_RST_DIGIT        8'h00
`define SSDD_RST_CONTROL      3'h0
`define SSDD_CTRL_FAST_BIT    0
`define SSDD_CTRL_BLINK_BIT   1
`define SSDD_CTRL_SYNC_BIT    2

// ****************************************************************
// timing on the multiplex clock
// ****************************************************************
`define SSDD_OSC_HZ           4000000
`define SSDD_SLOT_US          200
`define SSDD_SLOW_MILLIHZ     500
`define SSDD_FAST_MILLIHZ     1000
`define SSDD_SLOT_TICKS       ((`SSDD_OSC_HZ / 1000000) * `SSDD_SLOT_US)
`define SSDD_SLOW_HALF_TICKS  ((64'd1000 * `SSDD_OSC_HZ) / (64'd2 * `SSDD_SLOW_MILLIHZ))
`define SSDD_FAST_HALF_TICKS  ((64'd1000 * `SSDD_OSC_HZ) / (64'd2 * `SSDD_FAST_MILLIHZ))

`endif

// [ssdd_pkg.sv]
package ssdd_pkg;
	typedef logic [7:0] ssdd_byte_t;
	// {dp, a, b, c, d, e, f, g}
	typedef logic [7:0] ssdd_segs_t;
	typedef logic [2:0] ssdd_digit_idx_t;
endpackage : ssdd_pkg

// [ssdd_dec_if.sv]
`timescale 1ns/1ps
interface ssdd_dec_if;
	logic                decode_en;
	ssdd_pkg::ssdd_byte_t data;
	ssdd_pkg::ssdd_segs_t segs;
	modport requester (output decode_en, output data, input segs);
	modport decoder   (input decode_en, input data, output segs);
endinterface : ssdd_dec_if

// [ssdd_font.sv]
`timescale 1ns/1ps
module ssdd_font (
	// digit to translate
	ssdd_dec_if.decoder dec
);
	logic [6:0] font;

	always_comb begin
		case (dec.data[3:0])
			4'h0:    font = 7'h7e;
			4'h1:    font = 7'h30;
			4'h2:    font = 7'h6d;
			4'h3:    font = 7'h79;
			4'h4:    font = 7'h33;
			4'h5:    font = 7'h5b;
			4'h6:    font = 7'h5f;
			4'h7:    font = 7'h70;
			4'h8:    font = 7'h7f;
			4'h9:    font = 7'h7b;
			4'ha:    font = 7'h77;
			4'hb:    font = 7'h1f;
			4'hc:    font = 7'h4e;
			4'hd:    font = 7'h3d;
			4'he:    font = 7'h4f;
			4'hf:    font = 7'h47;
			default: font = 7'h00;
		endcase
	end

	// dp follows bit 7 in both modes
	assign dec.segs = dec.decode_en ? {dec.data[7], font}
	                                : dec.data;
endmodule : ssdd_font

// [ssdd_top.sv]
`timescale 1ns/1ps
`include "ssdd_defs.svh"
// Behaviour
// - one decode-select bit per digit, set decodes
// - decode uses only data bits 3..0
// - hex font segment patterns for 0..F
// - decode mode: dp equals data bit 7
// - raw mode: bit7 dp, bits 6..0 a..g
// - sync-bit control write restarts digit scan
// - blink rates derived from multiplex clock
// - sync bit set: write end clears counters
module ssdd_top #(
	parameter int unsigned SLOT_TICKS = `SSDD_SLOT_TICKS,
	parameter longint unsigned SLOW_HALF = `SSDD_SLOW_HALF_TICKS,
	parameter longint unsigned FAST_HALF = `SSDD_FAST_HALF_TICKS
) (
	// clock, reset, enable
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        ce,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// multiplex clock pin
	input  wire logic        multiplex_clock_input,
	// display
	output logic      [7:0]  segment_out,
	output logic      [7:0]  digit_enable,
	output logic             blink_phase
);
	// ****************************************************************
	// register file
	// ****************************************************************
	ssdd_pkg::ssdd_byte_t decode_sel_q, decode_sel_d;
	ssdd_pkg::ssdd_byte_t digit_q [8];
	ssdd_pkg::ssdd_byte_t digit_d [8];
	logic [2:0]           ctrl_q, ctrl_d;
	logic                 ack_q, ack_d;
	logic [31:0]          rdata_q, rdata_d;
	logic                 wr_acc;
	logic                 resync;
	logic [5:0]           idx;
	logic                 byte0_we;

	assign idx      = wb_adr_i[7:2];
	assign wr_acc   = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q;
	assign byte0_we = wr_acc & wb_sel_i[0];
	// write ends with the ack: the counterpart of chip-select rising
	assign resync   = byte0_we & (
		((idx == `SSDD_IDX_CONTROL) & wb_dat_i[`SSDD_CTRL_SYNC_BIT]) |
		((idx != `SSDD_IDX_CONTROL) & ctrl_q[`SSDD_CTRL_SYNC_BIT]));

	// scan state, declared early for the status read
	ssdd_pkg::ssdd_digit_idx_t scan_q, scan_d;
	logic                      phase_q, phase_d;

	always_comb begin
		decode_sel_d = decode_sel_q;
		ctrl_d       = ctrl_q;
		digit_d      = digit_q;
		ack_d        = wb_cyc_i & wb_stb_i & ~ack_q;
		rdata_d      = 32'h0000_0000;
		if (byte0_we && idx == `SSDD_IDX_DECODE_SEL) begin
			decode_sel_d = wb_dat_i[7:0];
		end
		if (byte0_we && idx == `SSDD_IDX_CONTROL) begin
			ctrl_d = wb_dat_i[2:0];
		end
		if (byte0_we && idx >= `SSDD_IDX_DIGIT_BASE && idx <= `SSDD_IDX_DIGIT_LAST) begin
			digit_d[idx[2:0]] = wb_dat_i[7:0];
		end
		if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q) begin
			if (idx == `SSDD_IDX_DECODE_SEL) begin
				rdata_d = {24'h00_0000, decode_sel_q};
			end else if (idx == `SSDD_IDX_CONTROL) begin
				rdata_d = {29'h0000_0000, ctrl_q};
			end else if (idx == `SSDD_IDX_STATUS) begin
				rdata_d = {28'h000_0000, phase_q, scan_q};
			end else if (idx >= `SSDD_IDX_DIGIT_BASE && idx <= `SSDD_IDX_DIGIT_LAST) begin
				rdata_d = {24'h00_0000, digit_q[idx[2:0]]};
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			decode_sel_q <= `SSDD_RST_DECODE_SEL;
			ctrl_q       <= `SSDD_RST_CONTROL;
			ack_q        <= 1'b0;
			rdata_q      <= 32'h0000_0000;
			for (int i = 0; i < 8; i++) begin
				digit_q[i] <= `SSDD_RST_DIGIT;
			end
		end else if (ce) begin
			decode_sel_q <= decode_sel_d;
			ctrl_q       <= ctrl_d;
			ack_q        <= ack_d;
			rdata_q      <= rdata_d;
			digit_q      <= digit_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdata_q;

	// ****************************************************************
	// multiplex clock pin: three stages, counted when 2nd and 3rd agree
	// ****************************************************************
	logic [2:0] osc_sync_q;
	logic       osc_lvl_q, osc_lvl_d;
	logic       osc_tick;

	always_comb begin
		osc_lvl_d = osc_lvl_q;
		if (osc_sync_q[1] == osc_sync_q[2]) begin
			osc_lvl_d = osc_sync_q[2];
		end
	end
	assign osc_tick = osc_lvl_d & ~osc_lvl_q;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			osc_sync_q <= 3'h0;
			osc_lvl_q  <= 1'b0;
		end else if (ce) begin
			osc_sync_q <= {osc_sync_q[1:0], multiplex_clock_input};
			osc_lvl_q  <= osc_lvl_d;
		end
	end

	// ****************************************************************
	// scan and blink dividers on multiplex clock ticks
	// ****************************************************************
	logic [31:0] slot_q, slot_d;
	logic [63:0] blink_q, blink_d;
	logic [63:0] half;

	// rates scale with the pin clock, so a slower pin blinks slower
	assign half = ctrl_q[`SSDD_CTRL_FAST_BIT] ? FAST_HALF : SLOW_HALF;

	always_comb begin
		slot_d  = slot_q;
		scan_d  = scan_q;
		blink_d = blink_q;
		phase_d = phase_q;
		if (resync) begin
			slot_d  = 32'h0000_0000;
			scan_d  = 3'h0;
			blink_d = 64'h0;
			phase_d = 1'b0;
		end else if (osc_tick) begin
			if (slot_q >= SLOT_TICKS - 1) begin
				slot_d = 32'h0000_0000;
				scan_d = 3'(scan_q + 3'h1);
			end else begin
				slot_d = slot_q + 32'h1;
			end
			if (blink_q >= half - 64'h1) begin
				blink_d = 64'h0;
				phase_d = ~phase_q & ctrl_q[`SSDD_CTRL_BLINK_BIT];
			end else begin
				blink_d = blink_q + 64'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			slot_q  <= 32'h0000_0000;
			scan_q  <= 3'h0;
			blink_q <= 64'h0;
			phase_q <= 1'b0;
		end else if (ce) begin
			slot_q  <= slot_d;
			scan_q  <= scan_d;
			blink_q <= blink_d;
			phase_q <= phase_d;
		end
	end

	// ****************************************************************
	// per-digit decode of the scanned digit
	// ****************************************************************
	ssdd_dec_if dec_bus ();

	assign dec_bus.decode_en = decode_sel_q[scan_q];
	assign dec_bus.data      = digit_q[scan_q];

	ssdd_font u_font (
		.dec (dec_bus.decoder)
	);

	ssdd_pkg::ssdd_segs_t seg_q;
	logic [7:0]           dig_q;
	logic [7:0]           dig_d;

	always_comb begin
		dig_d = 8'h00;
		dig_d[scan_q] = 1'b1;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			seg_q <= 8'h00;
			dig_q <= 8'h00;
		end else if (ce) begin
			seg_q <= dec_bus.segs;
			dig_q <= dig_d;
		end
	end

	assign segment_out  = seg_q;
	assign digit_enable = dig_q;
	assign blink_phase  = phase_q;
endmodule : ssdd_top

// [ssdd_sva.sv]
`timescale 1ns/1ps
// ****
// bus, scan and blink checks
// ****
module ssdd_chk (
	// clock, reset, enable
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        ce,
	// bus
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// display
	input wire logic [7:0]  digit_enable,
	input wire logic        blink_phase
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence sync_wr;
		wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]
			&& wb_adr_i[7:2] == 6'h04 && wb_dat_i[2];
	endsequence
	a_ack_answer: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o) else $error("no ack");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
	a_read_upper: assert property (
		wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits set");
	a_scan_onehot: assert property ($countones(digit_enable) <= 1) else $error("two digits");
	a_scan_order: assert property (
		$changed(digit_enable) && $past(digit_enable) != 8'h00 |->
		digit_enable == ($past(digit_enable) << 1) || digit_enable == 8'h01)
		else $error("scan order");
	a_sync_scan: assert property (sync_wr |-> ##[0:2] digit_enable == 8'h01)
		else $error("scan not restarted");
	a_sync_blink: assert property (sync_wr |-> ##[0:2] !blink_phase)
		else $error("blink not cleared");
	a_blink_hold: assert property ($changed(blink_phase) |=> $stable(blink_phase)[*8])
		else $error("blink too fast");
endmodule : ssdd_chk

bind ssdd_top ssdd_chk ssdd_chk_i (.clk, .resetn, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .digit_enable, .blink_phase);

// [ssdd_osc_model.sv]
`timescale 1ns/1ps
// ****
// external multiplex clock, one tick per 8 clk
// ****
module ssdd_osc_model (
	// system clock
	input  wire logic clk,
	// pin
	output logic      multiplex_clock_input
);
	logic [1:0] cnt_q;
	initial begin
		cnt_q = 2'h0;
		multiplex_clock_input = 1'b0;
	end
	// 4 clk high and low, well above the pin filter
	always @(posedge clk) begin
		cnt_q <= cnt_q + 2'h1;
		if (cnt_q == 2'h3) multiplex_clock_input <= !multiplex_clock_input;
	end
endmodule : ssdd_osc_model

// [tb_seven_segment_digit_decoder.sv]
`timescale 1ns/1ps
module tb_seven_segment_digit_decoder;
	logic        clk, resetn, cyc, stb, we, ack, osc, blink, seg_on, ce;
	logic [7:0]  adr, dsel, d, segs, de, last_de;
	logic [3:0]  sel;
	logic [31:0] dat_i, dat_o;
	logic [31:0] rq[$];
	logic [7:0]  exp_seg[8];
	logic [6:0]  font[16] = '{7'h7e, 7'h30, 7'h6d, 7'h79, 7'h33, 7'h5b, 7'h5f, 7'h70,
		7'h7f, 7'h7b, 7'h77, 7'h1f, 7'h4e, 7'h3d, 7'h4f, 7'h47};
	int          miscompares, n_compared, n, r, t;
	always #12.5 clk = !clk;
	ssdd_osc_model ssdd_osc_model_i (.clk(clk), .multiplex_clock_input(osc));
	// short counts: 4 ticks a slot, blink halves of 16 and 8 ticks
	ssdd_top #(.SLOT_TICKS(4), .SLOW_HALF(16), .FAST_HALF(8)) ssdd_top_i (.clk(clk),
		.resetn(resetn), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.multiplex_clock_input(osc), .segment_out(segs), .digit_enable(de),
		.blink_phase(blink));
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task complete_run;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	// reads note their expected byte for the monitor
	task wb(input logic w, input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_i <= {24'h0, v};
		if (!w) rq.push_back({24'h0, v});
		t = 0;
		do begin @(posedge clk); t++; end while (ack !== 1'b1 && t < 50);
		cyc <= 1'b0; stb <= 1'b0;
		if (t >= 50) begin miscompares++; complete_run(); end
	endtask : wb
	task wait_digit(input int k);
		t = 0;
		do begin @(posedge clk); t++; end while (de !== (8'h01 << k) && t < 400);
		if (t >= 400) begin miscompares++; complete_run(); end
	endtask : wait_digit
	task measure(input logic [7:0] ctrl, input int half);
		wb(1'b1, 8'h10, ctrl);
		t = 0;
		do begin @(posedge clk); t++; end while (blink !== 1'b1 && t < 1000);
		if (t >= 1000) begin
			miscompares++;
			complete_run();
		end
		n = 0;
		do begin @(posedge clk); n++; end while (blink === 1'b1 && n < 1000);
		chk("blink_half", n, half * 8);
	endtask : measure
	always @(posedge clk) begin
		if (ack === 1'b1 && we === 1'b0) chk("read", dat_o, rq.pop_front());
		if (seg_on && de !== last_de && $onehot(de))
			chk("segs", segs, exp_seg[$clog2(de)]);
		last_de <= de;
	end
	initial begin
		clk = 1'b0; resetn = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00;
		sel = 4'hf; dat_i = 32'h0; seg_on = 1'b0; last_de = 8'h00;
		miscompares = 0; n_compared = 0;
		ce = 1'b1;
		r = $urandom(9);
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		wb(1'b0, 8'h04, 8'h00);
		// unmapped place: write ignored, reads zero
		wb(1'b1, 8'h0c, 8'h5a);
		wb(1'b0, 8'h0c, 8'h00);
		// two decode rounds cover all 16 characters, then mixed and raw
		for (r = 0; r < 4; r++) begin
			dsel = (r < 2) ? 8'hff : ((r == 2) ? 8'h07 : 8'h00);
			wb(1'b1, 8'h04, dsel);
			wb(1'b0, 8'h04, dsel);
			for (n = 0; n < 8; n++) begin
				d = 8'($urandom);
				if (r < 2) d[3:0] = 4'(r * 8 + n);
				exp_seg[n] = dsel[n] ? {d[7], font[d[3:0]]} : d;
				wb(1'b1, 8'(8'h80 + 4 * n), d);
			end
			wait_digit(7);
			seg_on <= 1'b1;
			wait_digit(0);
			wait_digit(7);
			seg_on <= 1'b0;
		end
		measure(8'h03, 8);
		measure(8'h02, 16);
		repeat (20) @(posedge clk);
		wb(1'b1, 8'h10, 8'h07);
		repeat (2) @(posedge clk);
		chk("restart", de, 8'h01);
		wb(1'b0, 8'h14, 8'h00);
		// sync bit still set: any later write to another register restarts the scan too
		repeat (40) @(posedge clk);
		chk("scan_moved", de, 8'h02);
		wb(1'b1, 8'h80, 8'h00);
		repeat (2) @(posedge clk);
		chk("resync", de, 8'h01);
		chk("resync_blink", blink, 1'b0);
		// enable low: the scan must hold past a whole slot
		ce <= 1'b0;
		@(posedge clk);
		dsel = de;
		repeat (40) @(posedge clk);
		chk("freeze", de, dsel);
		ce <= 1'b1;
		complete_run();
	end
endmodule : tb_seven_segment_digit_decoder
